// [design/boot_mode_and_pm_map.sv]
`timescale 1ns/10ps
module boot_mode_and_pm_map #(
	parameter int unsigned BOOT_WORDS = 2048
) (
	// Clock, reset, enable
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	// Strap and bus request pins
	input  wire logic        memory_map_select_pin,
	input  wire logic        boot_source_select_pin,
	input  wire logic        bus_request_n,
	// External memory bus
	output logic [13:0]      pm_address_bus,
	output logic [23:0]      pm_data_out,
	output logic [23:0]      pm_data_oe,
	input  wire logic [23:0] pm_data_in,
	output logic             program_mem_select_n,
	output logic             boot_mem_select_n,
	output logic             rd_n,
	output logic             wr_n,
	output logic             cycle_clock_output,
	// Control word port
	input  wire logic [13:0] dm_reg_addr,
	input  wire logic        dm_reg_wr,
	input  wire logic [15:0] dm_reg_wdata,
	output logic [15:0]      dm_reg_rdata,
	// Core program memory port
	input  wire logic        core_pm_req,
	input  wire logic        core_pm_we,
	input  wire logic        core_pm_is_data,
	input  wire logic [13:0] core_pm_addr,
	input  wire logic [15:0] core_pm_wdata,
	output logic             core_pm_ack,
	output logic [1:0]       core_pm_target,
	output logic [23:0]      core_pm_rdata,
	input  wire logic        px_wr,
	input  wire logic [7:0]  px_wdata,
	output logic [7:0]       pm_low_byte_extension,
	// Core sequencing
	output logic             core_master_reset,
	output logic             core_fetch_enable,
	output logic [13:0]      core_start_addr,
	// Host port boot
	output logic             host_boot_req,
	input  wire logic        host_boot_done,
	// Internal RAM loader
	output logic             ram_wr_valid,
	input  wire logic        ram_wr_ready,
	output logic [10:0]      ram_wr_addr,
	output logic [23:0]      ram_wr_data
);
	localparam int FW = boot_map_pkg::RAM_ADDR_W + boot_map_pkg::WORD_W;

	logic [1:0]                rst_sync_q;
	logic                      rst_n_q;
	boot_map_pkg::boot_state_e state_q;
	logic                      memory_map_select_pin_q;
	logic [15:0]               autobuf_q;
	logic [15:0]               rom_wait_q;
	logic [15:0]               sysctl_q;
	logic                      force_q;
	logic [2:0]                wait_cnt_q;
	logic [1:0]                byte_sel_q;
	logic [12:0]               byte_idx_q;
	logic [10:0]               word_idx_q;
	logic [2:0]                page_q;
	logic [15:0]               word_q;
	logic                      acc_we_q;
	logic                      acc_data_q;
	logic [13:0]               acc_addr_q;
	logic [23:0]               acc_wdata_q;
	logic                      strap_take;
	logic                      force_take;
	logic                      boot_begin;
	logic                      byte_end;
	logic                      word_done;
	logic                      last_word;
	logic                      ram_hit;
	logic                      rom_hit;
	logic                      pm_start;
	logic                      pm_end;
	logic                      boot_rd;
	logic [15:0]               boot_addr;

	word_stream_if #(.WIDTH(FW)) fill_s ();
	word_stream_if #(.WIDTH(FW)) drain_s ();

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else if (clk_en) begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n_q           = rst_sync_q[1];
	assign core_master_reset = !rst_n_q;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	assign boot_rd    = (state_q == boot_map_pkg::ST_BOOT_RD);
	assign strap_take = (state_q == boot_map_pkg::ST_STRAP) && bus_request_n;
	assign force_take = (state_q == boot_map_pkg::ST_RUN) && force_q && !core_pm_ack;
	assign boot_begin = (strap_take && !memory_map_select_pin && !boot_source_select_pin)
		|| force_take;
	assign byte_end   = boot_rd && (wait_cnt_q == 3'h0);
	assign word_done  = byte_end && (byte_sel_q == boot_map_pkg::LAST_BYTE_SEL);
	assign last_word  = (word_idx_q == 11'(BOOT_WORDS - 1));
	assign ram_hit    = memory_map_select_pin_q ? (core_pm_addr >= boot_map_pkg::RAM_HIGH_BASE)
		: (core_pm_addr <= boot_map_pkg::RAM_LOW_END);
	assign rom_hit    = rom_wait_q[boot_map_pkg::ROM_ENABLE_BIT] && !ram_hit
		&& (core_pm_addr >= boot_map_pkg::ROM_BASE)
		&& (core_pm_addr <= boot_map_pkg::ROM_END);
	assign pm_start   = (state_q == boot_map_pkg::ST_RUN) && !force_q && core_pm_req
		&& !core_pm_ack && !ram_hit && !rom_hit;
	assign pm_end     = (state_q == boot_map_pkg::ST_PM_ACC) && (wait_cnt_q == 3'h0);
	assign boot_addr  = {page_q, byte_idx_q};

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q         <= boot_map_pkg::ST_STRAP;
			memory_map_select_pin_q          <= 1'b0;
			core_start_addr <= boot_map_pkg::START_RAM;
		end else if (clk_en) begin
			case (state_q)
				boot_map_pkg::ST_STRAP: begin
					if (strap_take) begin
						memory_map_select_pin_q <= memory_map_select_pin;
						if (memory_map_select_pin) begin
							state_q         <= boot_map_pkg::ST_RUN;
							core_start_addr <= boot_source_select_pin ?
								boot_map_pkg::START_ROM : boot_map_pkg::START_RAM;
						end else if (boot_source_select_pin) begin
							state_q <= boot_map_pkg::ST_HOST;
						end else begin
							state_q <= boot_map_pkg::ST_BOOT_RD;
						end
					end
				end
				boot_map_pkg::ST_BOOT_RD: begin
					if (word_done && last_word) begin
						state_q <= boot_map_pkg::ST_BOOT_DRAIN;
					end else if (byte_end) begin
						state_q <= boot_map_pkg::ST_BOOT_GAP;
					end
				end
				// Next byte only once a word slot is free, so the push never stalls
				boot_map_pkg::ST_BOOT_GAP: begin
					if (fill_s.ready) begin
						state_q <= boot_map_pkg::ST_BOOT_RD;
					end
				end
				boot_map_pkg::ST_BOOT_DRAIN: begin
					if (!drain_s.valid) begin
						state_q         <= boot_map_pkg::ST_RUN;
						core_start_addr <= boot_map_pkg::START_RAM;
					end
				end
				boot_map_pkg::ST_HOST: begin
					if (host_boot_done) begin
						state_q         <= boot_map_pkg::ST_RUN;
						core_start_addr <= boot_map_pkg::START_RAM;
					end
				end
				boot_map_pkg::ST_RUN: begin
					if (force_take) begin
						state_q <= boot_map_pkg::ST_BOOT_RD;
					end else if (pm_start) begin
						state_q <= boot_map_pkg::ST_PM_ACC;
					end
				end
				boot_map_pkg::ST_PM_ACC: begin
					if (pm_end) begin
						state_q <= boot_map_pkg::ST_RUN;
					end
				end
				default: begin
					state_q <= boot_map_pkg::ST_STRAP;
				end
			endcase
		end
	end
	assign core_fetch_enable = (state_q == boot_map_pkg::ST_RUN)
		|| (state_q == boot_map_pkg::ST_PM_ACC);
	assign host_boot_req     = (state_q == boot_map_pkg::ST_HOST);

	// ----------------------------------------
	// Wait states
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wait_cnt_q <= 3'h0;
		end else if (clk_en) begin
			if (boot_begin || (state_q == boot_map_pkg::ST_BOOT_GAP && fill_s.ready)) begin
				wait_cnt_q <= sysctl_q[boot_map_pkg::BOOT_WAIT_LSB +: 3];
			end else if (pm_start) begin
				wait_cnt_q <= sysctl_q[boot_map_pkg::PM_WAIT_LSB +: 3];
			end else if (wait_cnt_q != 3'h0) begin
				wait_cnt_q <= wait_cnt_q - 3'h1;
			end
		end
	end

	// ----------------------------------------
	// Boot byte assembly
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			byte_sel_q <= 2'h0;
			byte_idx_q <= 13'h0;
			word_idx_q <= 11'h0;
			page_q     <= 3'h0;
			word_q     <= 16'h0;
		end else if (clk_en) begin
			if (boot_begin) begin
				byte_sel_q <= 2'h0;
				byte_idx_q <= 13'h0;
				word_idx_q <= 11'h0;
				page_q     <= sysctl_q[boot_map_pkg::BOOT_PAGE_LSB +: 3];
			end else if (byte_end) begin
				word_q     <= {word_q[7:0], pm_data_in[15:8]};
				byte_idx_q <= byte_idx_q + 13'h1;
				byte_sel_q <= word_done ? 2'h0 : byte_sel_q + 2'h1;
				if (word_done) begin
					word_idx_q <= word_idx_q + 11'h1;
				end
			end
		end
	end
	assign fill_s.valid = word_done;
	assign fill_s.data  = {word_idx_q, word_q, pm_data_in[15:8]};

	// Depth hides short RAM stalls without slowing the byte reads
	word_fifo #(
		.WIDTH (FW),
		.DEPTH (boot_map_pkg::FIFO_DEPTH)
	) u_word_fifo (
		.clk    (ref_clk),
		.rst_n  (rst_n_q),
		.clk_en (clk_en),
		.in_s   (fill_s),
		.out_s  (drain_s)
	);
	assign ram_wr_valid  = drain_s.valid;
	assign drain_s.ready = ram_wr_ready;
	assign ram_wr_addr   = drain_s.data[FW-1 -: boot_map_pkg::RAM_ADDR_W];
	assign ram_wr_data   = drain_s.data[boot_map_pkg::WORD_W-1:0];

	// ----------------------------------------
	// External program access
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			acc_we_q              <= 1'b0;
			acc_data_q            <= 1'b0;
			acc_addr_q            <= 14'h0;
			acc_wdata_q           <= 24'h0;
			core_pm_ack           <= 1'b0;
			core_pm_target        <= boot_map_pkg::TGT_EXT;
			core_pm_rdata         <= 24'h0;
			pm_low_byte_extension <= 8'h0;
		end else if (clk_en) begin
			core_pm_ack <= pm_end || ((state_q == boot_map_pkg::ST_RUN) && !force_q
				&& core_pm_req && !core_pm_ack && (ram_hit || rom_hit));
			if (state_q == boot_map_pkg::ST_RUN && core_pm_req) begin
				core_pm_target <= ram_hit ? boot_map_pkg::TGT_RAM :
					(rom_hit ? boot_map_pkg::TGT_ROM : boot_map_pkg::TGT_EXT);
			end
			if (pm_start) begin
				acc_we_q    <= core_pm_we;
				acc_data_q  <= core_pm_is_data;
				acc_addr_q  <= core_pm_addr;
				acc_wdata_q <= {core_pm_wdata, pm_low_byte_extension};
			end
			if (pm_end && !acc_we_q) begin
				core_pm_rdata <= pm_data_in;
			end
			if (pm_end && !acc_we_q && acc_data_q) begin
				pm_low_byte_extension <= pm_data_in[7:0];
			end else if (px_wr) begin
				pm_low_byte_extension <= px_wdata;
			end
		end
	end

	// Strobes only ever appear inside a select window
	assign boot_mem_select_n    = !boot_rd;
	assign program_mem_select_n = (state_q != boot_map_pkg::ST_PM_ACC);
	assign rd_n                 = !(boot_rd || (!program_mem_select_n && !acc_we_q));
	assign wr_n                 = !(!program_mem_select_n && acc_we_q);
	assign pm_address_bus       = boot_rd ? boot_addr[13:0] : acc_addr_q;
	assign pm_data_out          = boot_rd ? {boot_addr[15:14], 22'h0} : acc_wdata_q;
	assign pm_data_oe           = boot_rd ? boot_map_pkg::BOOT_OE
		: {24{!program_mem_select_n && acc_we_q}};
	// Gated copy of the cycle clock; a flop could only give half rate
	assign cycle_clock_output   = ref_clk && !autobuf_q[boot_map_pkg::CYCLE_CLOCK_OUTPUT_DIS_BIT];

	// ----------------------------------------
	// Control words
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			autobuf_q  <= boot_map_pkg::AUTOBUF_RESET;
			rom_wait_q <= boot_map_pkg::ROM_WAIT_RESET;
			sysctl_q   <= boot_map_pkg::SYS_CONTROL_RESET;
			force_q    <= 1'b0;
		end else if (clk_en) begin
			if (dm_reg_wr && dm_reg_addr == boot_map_pkg::ADDR_AUTOBUF_CYCLE_CLOCK_OUTPUT) begin
				autobuf_q <= dm_reg_wdata;
			end
			if (strap_take) begin
				rom_wait_q[boot_map_pkg::ROM_ENABLE_BIT] <= memory_map_select_pin
					&& boot_source_select_pin;
			end else if (dm_reg_wr && dm_reg_addr == boot_map_pkg::ADDR_ROM_WAIT) begin
				rom_wait_q <= dm_reg_wdata;
			end
			if (dm_reg_wr && dm_reg_addr == boot_map_pkg::ADDR_SYS_CONTROL) begin
				sysctl_q <= {7'h0, dm_reg_wdata[8:0]};
			end
			// A new force request wins over the clear of the one being taken
			if (dm_reg_wr && dm_reg_addr == boot_map_pkg::ADDR_SYS_CONTROL
				&& dm_reg_wdata[boot_map_pkg::FORCE_BOOT_BIT]) begin
				force_q <= 1'b1;
			end else if (force_take) begin
				force_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dm_reg_rdata <= 16'h0;
		end else if (clk_en) begin
			case (dm_reg_addr)
				boot_map_pkg::ADDR_AUTOBUF_CYCLE_CLOCK_OUTPUT: dm_reg_rdata <= autobuf_q;
				boot_map_pkg::ADDR_ROM_WAIT:       dm_reg_rdata <= rom_wait_q;
				boot_map_pkg::ADDR_SYS_CONTROL: begin
					dm_reg_rdata <= {6'h0, force_q || !core_fetch_enable, sysctl_q[8:0]};
				end
				default:                           dm_reg_rdata <= 16'h0;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [3:0] boot_len_q;
	logic [3:0] pm_len_q;
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			boot_len_q <= 4'h0;
			pm_len_q   <= 4'h0;
		end else if (clk_en) begin
			boot_len_q <= boot_mem_select_n ? 4'h0 : boot_len_q + 4'h1;
			pm_len_q   <= program_mem_select_n ? 4'h0 : pm_len_q + 4'h1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n_q);

	chk_rom_strap_reset: assert property (strap_take && clk_en |=>
		rom_wait_q[boot_map_pkg::ROM_ENABLE_BIT]
		== (memory_map_select_pin_q && core_start_addr == boot_map_pkg::START_ROM))
		else $error("rom enable wrong after strap capture");
	chk_standalone_start: assert property (strap_take && clk_en && memory_map_select_pin
		&& boot_source_select_pin |=> core_fetch_enable && core_start_addr == 14'h0800)
		else $error("stand-alone mode did not start at rom base");
	chk_noboot_start: assert property (strap_take && clk_en && memory_map_select_pin
		&& !boot_source_select_pin |=> core_fetch_enable && core_start_addr == 14'h0000)
		else $error("no-boot mode did not start at zero");
	chk_boot_strobes: assert property (!boot_mem_select_n |-> !rd_n && wr_n
		&& program_mem_select_n && pm_data_oe == 24'hc00000)
		else $error("boot access strobes or drive wrong");
	chk_boot_wait_len: assert property ($rose(boot_mem_select_n) |->
		boot_len_q == {1'b0, sysctl_q[5:3]} + 4'h1)
		else $error("boot access length differs from wait setting");
	chk_pm_wait_len: assert property ($rose(program_mem_select_n) |->
		pm_len_q == {1'b0, sysctl_q[2:0]} + 4'h1 && core_pm_ack)
		else $error("program access length or ack wrong");
	chk_pm_strobes: assert property (!program_mem_select_n |-> (rd_n != wr_n)
		&& boot_mem_select_n)
		else $error("program access strobes wrong");
	chk_px_capture: assert property (pm_end && clk_en && !acc_we_q && acc_data_q |=>
		pm_low_byte_extension == $past(pm_data_in[7:0]))
		else $error("extension byte not captured");
	chk_fetch_after_boot: assert property ($rose(core_fetch_enable) && memory_map_select_pin_q == 1'b0
		&& !host_boot_req |-> !ram_wr_valid && $past(state_q) != boot_map_pkg::ST_BOOT_RD)
		else $error("fetch released before boot finished");
	cov_eprom_boot: cover property (state_q == boot_map_pkg::ST_BOOT_DRAIN ##1
		state_q == boot_map_pkg::ST_RUN);
	cov_host_boot: cover property (host_boot_req ##1 !host_boot_req);
	cov_fifo_full: cover property (!fill_s.ready && !ram_wr_ready);
	cov_ext_read: cover property (pm_end && !acc_we_q && acc_data_q);
endmodule : boot_mode_and_pm_map

// [include/boot_map_pkg.sv]
package boot_map_pkg;
	// ----------------------------------------
	// Control words in data-memory space
	// ----------------------------------------
	localparam logic [13:0] ADDR_AUTOBUF_CYCLE_CLOCK_OUTPUT = 14'h3ff3;
	localparam logic [13:0] ADDR_ROM_WAIT       = 14'h3ffe;
	localparam logic [13:0] ADDR_SYS_CONTROL    = 14'h3fff;
	localparam int          CYCLE_CLOCK_OUTPUT_DIS_BIT      = 14;
	localparam int          ROM_ENABLE_BIT      = 15;
	localparam logic [15:0] AUTOBUF_RESET       = 16'h0000;
	localparam logic [15:0] ROM_WAIT_RESET      = 16'h7fff;
	localparam logic [15:0] SYS_CONTROL_RESET   = 16'h003f;
	localparam int          PM_WAIT_LSB         = 0;
	localparam int          BOOT_WAIT_LSB       = 3;
	localparam int          BOOT_PAGE_LSB       = 6;
	localparam int          FORCE_BOOT_BIT      = 9;
	// ----------------------------------------
	// Program memory map
	// ----------------------------------------
	localparam logic [13:0] RAM_LOW_END   = 14'h07ff;
	localparam logic [13:0] RAM_HIGH_BASE = 14'h3800;
	localparam logic [13:0] ROM_BASE      = 14'h0800;
	localparam logic [13:0] ROM_END       = 14'h27ff;
	localparam logic [13:0] START_RAM     = 14'h0000;
	localparam logic [13:0] START_ROM     = 14'h0800;
	// ----------------------------------------
	// Boot loader and buffering
	// ----------------------------------------
	localparam int          WORD_W        = 24;
	localparam int          RAM_ADDR_W    = 11;
	localparam int          FIFO_DEPTH    = 4;
	localparam logic [1:0]  LAST_BYTE_SEL = 2'h2;
	localparam logic [23:0] BOOT_OE       = 24'hc00000;
	localparam logic [1:0]  TGT_EXT       = 2'h0;
	localparam logic [1:0]  TGT_RAM       = 2'h1;
	localparam logic [1:0]  TGT_ROM       = 2'h2;
	typedef enum logic [2:0] {
		ST_STRAP      = 3'h0,
		ST_BOOT_RD    = 3'h1,
		ST_BOOT_GAP   = 3'h2,
		ST_BOOT_DRAIN = 3'h3,
		ST_HOST       = 3'h4,
		ST_RUN        = 3'h5,
		ST_PM_ACC     = 3'h6
	} boot_state_e;
endpackage : boot_map_pkg

// [include/word_stream_if.sv]
`timescale 1ns/10ps
interface word_stream_if #(parameter int WIDTH = 8);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : word_stream_if

// [design/word_fifo.sv]
`timescale 1ns/10ps
module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic    clk,
	input wire logic    rst_n,
	input wire logic    clk_en,
	// Streams
	word_stream_if.snk  in_s,
	word_stream_if.src  out_s
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_q;
	logic [PW-1:0]    rd_ptr_q;
	logic [PW:0]      count_q;
	logic             push;
	logic             pop;

	assign in_s.ready  = (count_q != (PW+1)'(DEPTH));
	assign out_s.valid = (count_q != '0);
	assign out_s.data  = mem[rd_ptr_q];
	assign push        = clk_en && in_s.valid && in_s.ready;
	assign pop         = clk_en && out_s.valid && out_s.ready;

	// ----------------------------------------
	// Storage, no reset needed on data
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_q] <= in_s.data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule : word_fifo

// [verification/boot_eprom_model.sv]
`timescale 1ns/10ps
module boot_eprom_model (
	// Bus pins from the block
	input  wire logic        ref_clk,
	input  wire logic [13:0] pm_address_bus,
	input  wire logic [23:0] pm_data_out,
	input  wire logic [23:0] pm_data_oe,
	input  wire logic        program_mem_select_n,
	input  wire logic        boot_mem_select_n,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	// Resolved bus level
	output logic [23:0]      pm_data_in
);
	logic [23:0] mem [16];
	logic [23:0] last_q = '0;
	logic [23:0] v;
	logic [15:0] ba;
	assign ba = {pm_data_out[23:22], pm_address_bus};
	// Undriven lines toggle so a stale value never looks valid
	always_comb begin
		if (!boot_mem_select_n && !rd_n) begin
			v = {~last_q[23:16], ba[7:0] ^ {5'h0, ba[15:13]}, ~last_q[7:0]};
		end else if (!program_mem_select_n && !rd_n) begin
			v = mem[pm_address_bus[3:0]];
		end else begin
			v = ~last_q;
		end
	end
	assign pm_data_in = (pm_data_oe & pm_data_out) | (~pm_data_oe & v);
	always_ff @(posedge ref_clk) begin
		last_q <= v;
		if (!program_mem_select_n && !wr_n) mem[pm_address_bus[3:0]] <= pm_data_out;
	end
endmodule : boot_eprom_model

// [verification/boot_mode_and_pm_map_tb.sv]
`timescale 1ns/10ps
module boot_mode_and_pm_map_tb;
	logic        ref_clk = 0, reset_n = 0, clk_en = 1, bus_request_n = 1, dm_reg_wr = 0;
	logic        memory_map_select_pin = 0, boot_source_select_pin = 0, px_wr = 0;
	logic        core_pm_req = 0, core_pm_we = 0, core_pm_is_data = 0;
	logic        host_boot_done = 0, ram_wr_ready = 0;
	logic [13:0] dm_reg_addr = '0, core_pm_addr = '0, pm_address_bus, core_start_addr;
	logic [15:0] dm_reg_wdata = '0, core_pm_wdata = '0, dm_reg_rdata, b;
	logic [23:0] pm_data_out, pm_data_oe, pm_data_in, core_pm_rdata, ram_wr_data;
	logic [7:0]  px_wdata = '0, pm_low_byte_extension;
	logic [10:0] ram_wr_addr;
	logic [1:0]  core_pm_target;
	logic        program_mem_select_n, boot_mem_select_n, rd_n, wr_n, cycle_clock_output;
	logic        core_pm_ack, core_master_reset, core_fetch_enable, host_boot_req, ram_wr_valid;
	logic [2:0]  page = '0;
	logic [13:0] ta [4] = '{14'h0010, 14'h0800, 14'h27ff, 14'h2800};
	logic [1:0]  tt [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
	int          errors = 0, comparisons = 0, k = 0, n = 0, cyc = 0;
	// ----------------------------------------
	// Design, memory model, helpers
	// ----------------------------------------
	boot_mode_and_pm_map #(.BOOT_WORDS(6)) dut (.*);
	boot_eprom_model mem_model (.*);
	always #50 ref_clk = ~ref_clk;
	// Slow drain so the loader fifo fills and refuses
	always @(posedge ref_clk) begin
		#1;
		cyc++;
		ram_wr_ready = (cyc[5:0] == 6'h0);
	end
	function automatic logic [7:0] f(input logic [15:0] a);
		return a[7:0] ^ {5'h0, a[15:13]};
	endfunction : f
	task check(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task complete_run;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task wr(input logic [13:0] a, input logic [15:0] d);
		@(posedge ref_clk); #1;
		dm_reg_addr = a; dm_reg_wdata = d; dm_reg_wr = 1'h1;
		@(posedge ref_clk); #1;
		dm_reg_wr = 1'h0;
	endtask : wr
	task rdc(input logic [13:0] a, input logic [15:0] e);
		@(posedge ref_clk); #1;
		dm_reg_addr = a;
		repeat (2) @(posedge ref_clk);
		#1 check(dm_reg_rdata, e);
	endtask : rdc
	task acc(input logic we, input logic dat, input logic [13:0] a, input logic [15:0] d);
		n = 0;
		@(posedge ref_clk); #1;
		core_pm_req = 1'h1; core_pm_we = we; core_pm_is_data = dat;
		core_pm_addr = a; core_pm_wdata = d;
		for (int i = 0; i < 40; i++) begin
			@(posedge ref_clk); #1;
			if (!program_mem_select_n && (we ? !wr_n : !rd_n)) n++;
			if (core_pm_ack === 1'b1) break;
		end
		core_pm_req = 1'h0;
	endtask : acc
	task wait_fetch;
		for (int i = 0; i < 4000; i++) begin
			@(posedge ref_clk); #1;
			if (core_fetch_enable === 1'b1) break;
		end
	endtask : wait_fetch
	task do_reset(input logic m, input logic s);
		#1 reset_n = 1'h0;
		memory_map_select_pin = m; boot_source_select_pin = s; k = 0;
		repeat (16) @(posedge ref_clk);
		#1 check(core_master_reset, 1);
		check(core_fetch_enable, 0);
		reset_n = 1'h1;
	endtask : do_reset
	// Each word loaded into RAM checked against the EPROM bytes
	always @(posedge ref_clk) if (ram_wr_valid === 1'b1 && ram_wr_ready === 1'b1) begin
		b = {page, 13'h0} + 16'(3 * k);
		check(ram_wr_addr, k);
		check(ram_wr_data, {f(b), f(b + 16'h1), f(b + 16'h2)});
		k++;
	end
	initial begin
		#3000000 errors++;
		complete_run();
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		do_reset(1'h0, 1'h0);
		wait_fetch();
		check(k, 6);
		check(core_master_reset, 0);
		check(core_start_addr, 14'h0000);
		rdc(14'h3ff3, 16'h0000);
		rdc(14'h3ffe, 16'h7fff);
		rdc(14'h3fff, 16'h003f);
		rdc(14'h3ff0, 16'h0000);
		$display("test reset boot done");
		page = 3'h1; k = 0;
		wr(14'h3fff, 16'h0240);
		repeat (4) @(posedge ref_clk);
		#1 check(core_fetch_enable, 0);
		wait_fetch();
		check(k, 6);
		rdc(14'h3fff, 16'h0040);
		$display("test forced boot done");
		@(posedge ref_clk); #1 px_wdata = 8'hab; px_wr = 1'h1;
		@(posedge ref_clk); #1 px_wr = 1'h0;
		acc(1'h1, 1'h1, 14'h3000, 16'h1234);
		check(n, 1);
		@(posedge ref_clk); #1 px_wdata = 8'hcd; px_wr = 1'h1;
		@(posedge ref_clk); #1 px_wr = 1'h0;
		acc(1'h0, 1'h1, 14'h3000, 16'h0000);
		check(core_pm_rdata, 24'h1234ab);
		check(pm_low_byte_extension, 8'hab);
		wr(14'h3fff, 16'h0007);
		acc(1'h0, 1'h0, 14'h3000, 16'h0000);
		check(n, 8);
		wr(14'h3ffe, 16'h8000);
		for (int j = 0; j < 4; j++) begin
			acc(1'h0, 1'h0, ta[j], 16'h0000);
			check(core_pm_target, tt[j]);
		end
		wr(14'h3ffe, 16'h0000);
		acc(1'h0, 1'h0, 14'h0800, 16'h0000);
		check(core_pm_target, 2'h0);
		wr(14'h3ff3, 16'h4000);
		@(posedge ref_clk) #10 check(cycle_clock_output, 0);
		wr(14'h3ff3, 16'h0000);
		@(posedge ref_clk) #10 check(cycle_clock_output, 1);
		$display("test program memory done");
		for (int s = 1; s < 4; s++) begin
			bus_request_n = (s != 2);
			do_reset(s[1], s[0]);
			if (s == 1) begin
				repeat (10) @(posedge ref_clk);
				#1 check(host_boot_req, 1);
				clk_en = 1'h0;
				host_boot_done = 1'h1;
				repeat (3) @(posedge ref_clk);
				#1 check(host_boot_req, 1);
				clk_en = 1'h1;
				@(posedge ref_clk) #1 host_boot_done = 1'h0;
			end
			if (s == 2) begin
				repeat (10) @(posedge ref_clk);
				#1 check(core_fetch_enable, 0);
				bus_request_n = 1'h1;
			end
			wait_fetch();
			check(k, 0);
			check(core_start_addr, (s == 3) ? 14'h0800 : 14'h0000);
			rdc(14'h3ffe, (s == 3) ? 16'hffff : 16'h7fff);
			if (s == 2) begin
				acc(1'h0, 1'h0, 14'h3800, 16'h0000);
				check(core_pm_target, 2'h1);
				acc(1'h0, 1'h0, 14'h0000, 16'h0000);
				check(core_pm_target, 2'h0);
			end
		end
		$display("test strap modes done");
		complete_run();
	end
endmodule : boot_mode_and_pm_map_tb
